// File: core/plfs_pkg.sv
// Package of constants and types shared by the programmer end and the device end
// Function
// - Protection programming command is 0x20
// - Data bits 2,1 select protection; rest ones
// - Write low byte step commits protection data
// - Protection bits clear only by chip erase; the device also reloads them to PROT_RESET on srst_i
// - Configuration read command is 0x04
// - Byte select zero: fuses on bits 4..0
// - Byte select one: protection bits 2,1
// - Read enable high releases the data lines
// - Signature command 0x08, address 0..2 read
// - Address 0, byte select one: calibration
// - Busy within 2.5 us, ready 0.5-0.9 ms
package plfs_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_PROT_PROG = 8'h20;
	localparam logic [7:0] CMD_CFG_READ = 8'h04;
	localparam logic [7:0] CMD_SIG_READ = 8'h08;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int PROT_BIT_2 = 2;
	localparam int PROT_BIT_1 = 1;
	localparam logic [7:0] PROT_MASK = 8'h06;
	localparam logic [7:0] RESERVED_ONES = 8'hf9;
	localparam logic [1:0] PROT_RESET = 2'h3;
	localparam logic [4:0] FUSE_RESET = 5'h1f;
	localparam int FUSE_WIDTH = 5;
	localparam logic [7:0] SIG_BYTE_0 = 8'h5a;
	localparam logic [7:0] SIG_BYTE_1 = 8'ha5;
	localparam logic [7:0] SIG_BYTE_2 = 8'h3c;
	localparam logic [7:0] CAL_BYTE = 8'h80;
	localparam logic [7:0] SIG_LAST_ADDR = 8'h02;

	// ----------------------------------------
	// Timing: clock 200 MHz
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int BUSY_MAX_NS = 2500;
	localparam int PROG_MIN_US_X10 = 5;
	localparam int PROG_MAX_US_X10 = 9;
	localparam int BUSY_DELAY_CYC = (BUSY_MAX_NS * CLK_MHZ) / 1000 / 2;
	localparam int PROG_MIN_CYC = (PROG_MIN_US_X10 * CLK_MHZ * 1000 + 9) / 10;
	localparam int PROG_MAX_CYC = (PROG_MAX_US_X10 * CLK_MHZ * 1000) / 10;
	localparam int PROG_CYC_DEF = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;
	localparam int CNT_W = 20;

	// Device state machine
	typedef enum logic [1:0] {
		PLFS_IDLE = 2'b00,
		PLFS_WAIT = 2'b01,
		PLFS_BUSY = 2'b11
	} plfs_dev_state_t;

	// Programmer state machine
	typedef enum logic [2:0] {
		PLFS_P_IDLE = 3'b000,
		PLFS_P_CMD = 3'b001,
		PLFS_P_ADDR = 3'b011,
		PLFS_P_DATA = 3'b010,
		PLFS_P_WR = 3'b110,
		PLFS_P_WAIT = 3'b111,
		PLFS_P_RD = 3'b101,
		PLFS_P_DONE = 3'b100
	} plfs_prg_state_t;

	// Programmer operation codes
	localparam logic [1:0] OP_PROT = 2'h0;
	localparam logic [1:0] OP_CFG = 2'h1;
	localparam logic [1:0] OP_SIG = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;

	// Host register map of the programmer
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_DATA = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_RESULT = 4'h3;

endpackage : plfs_pkg

// File: core/plfs_if.sv
// Interface joining the parallel programmer and the device
`timescale 1ns/1ps
`default_nettype none
interface plfs_if;
	logic [7:0] data_prg;
	logic data_prg_oe_n;
	logic [7:0] data_dev;
	logic data_dev_oe_n;
	logic [7:0] data_bus;
	logic [1:0] xa;
	logic load_strobe;
	logic read_en_n;
	logic byte_select_line;
	logic write_strobe_n;
	logic ready_busy_flag;

	// Resolved data lines; all ones stands for a floating bus
	assign data_bus = !data_dev_oe_n ? data_dev : (!data_prg_oe_n ? data_prg : 8'hff);

	modport prg (
		output data_prg, data_prg_oe_n, xa, load_strobe, read_en_n, byte_select_line, write_strobe_n,
		input data_bus, ready_busy_flag
	);
	modport dev (
		output data_dev, data_dev_oe_n, ready_busy_flag,
		input data_bus, xa, load_strobe, read_en_n, byte_select_line, write_strobe_n
	);
endinterface : plfs_if
`default_nettype wire

// File: core/plfs_device.sv
// Device end: command latch, configuration store and busy timing
`timescale 1ns/1ps
`default_nettype none
module plfs_device #(
	parameter int PROG_CYC = plfs_pkg::PROG_CYC_DEF
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Link
	plfs_if.dev link,
	// Fuse values from the store
	input wire logic [plfs_pkg::FUSE_WIDTH-1:0] fuse_i,
	// Current protection bits
	output logic [1:0] prot_o
);
	import plfs_pkg::*;

	typedef struct packed {
		logic [2:0] wr_s;
		logic [2:0] rd_s;
		logic [2:0] ld_s;
		logic [7:0] cmd;
		logic [7:0] addr;
		logic [7:0] data;
		logic [1:0] prot;
		logic [4:0] fuse;
		logic [7:0] dout;
		logic oe_n;
		logic rdy;
		logic [CNT_W-1:0] cnt;
		plfs_dev_state_t st;
	} plfs_dev_t;

	plfs_dev_t s_q;
	plfs_dev_t s_d;
	logic [7:0] din_s1_q;
	logic [7:0] din_s2_q;
	logic [1:0] xa_s1_q;
	logic [1:0] xa_s2_q;
	logic bs_s1_q;
	logic bs_s2_q;

	// Read mux for the addressed byte
	function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [7:0] addr,
		input logic bs, input logic [1:0] prot, input logic [4:0] fuse);
		logic [7:0] r;
		r = 8'hff;
		if (cmd == CMD_CFG_READ) begin
			r = bs ? {5'h1f, prot, 1'b1} : {3'h7, fuse};
		end else if (cmd == CMD_SIG_READ) begin
			if (bs) begin
				r = (addr == 8'h00) ? CAL_BYTE : 8'hff;
			end else begin
				unique case (addr)
					8'h00: r = SIG_BYTE_0;
					8'h01: r = SIG_BYTE_1;
					SIG_LAST_ADDR: r = SIG_BYTE_2;
					default: r = 8'hff;
				endcase
			end
		end
		return r;
	endfunction : read_byte

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.wr_s = {s_q.wr_s[1:0], link.write_strobe_n};
		s_d.rd_s = {s_q.rd_s[1:0], link.read_en_n};
		s_d.ld_s = {s_q.ld_s[1:0], link.load_strobe};
		s_d.fuse = fuse_i;
		// Load strobe rising edge latches command, address or data
		if (s_q.ld_s[1] && !s_q.ld_s[2] && s_q.rdy) begin
			unique case (xa_s2_q)
				2'h2: s_d.cmd = din_s2_q;
				2'h0: s_d.addr = din_s2_q;
				2'h1: s_d.data = din_s2_q;
				default: s_d.cmd = s_q.cmd;
			endcase
		end
		// Read enable low drives data; high releases the lines
		if (!s_q.rd_s[1]) begin
			s_d.oe_n = 1'b0;
			s_d.dout = read_byte(s_q.cmd, s_q.addr, bs_s2_q, s_q.prot, s_q.fuse);
		end else begin
			s_d.oe_n = 1'b1;
		end
		unique case (s_q.st)
			PLFS_IDLE: begin
				if (!s_q.wr_s[1] && s_q.wr_s[2]) begin
					s_d.st = PLFS_WAIT;
					s_d.cnt = '0;
				end
			end
			PLFS_WAIT: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == CNT_W'(BUSY_DELAY_CYC)) begin
					s_d.rdy = 1'b0;
					s_d.st = PLFS_BUSY;
				end
			end
			PLFS_BUSY: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt >= CNT_W'(PROG_CYC)) begin
					s_d.rdy = 1'b1;
					s_d.st = PLFS_IDLE;
					if (s_q.cmd == CMD_PROT_PROG) begin
						s_d.prot = s_q.prot & {s_q.data[PROT_BIT_2], s_q.data[PROT_BIT_1]};
					end else if (s_q.cmd == CMD_CHIP_ERASE) begin
						s_d.prot = PROT_RESET;
					end
				end
			end
			default: s_d.st = PLFS_IDLE;
		endcase
	end

	// State registers and pin synchronisers
	always_ff @(posedge mclk_i) begin
		din_s1_q <= link.data_bus;
		din_s2_q <= din_s1_q;
		xa_s1_q <= link.xa;
		xa_s2_q <= xa_s1_q;
		bs_s1_q <= link.byte_select_line;
		bs_s2_q <= bs_s1_q;
		if (srst_i) begin
			s_q <= '{wr_s: 3'h7, rd_s: 3'h7, ld_s: 3'h0, cmd: 8'h00, addr: 8'h00, data: 8'hff,
				prot: PROT_RESET, fuse: FUSE_RESET, dout: 8'hff, oe_n: 1'b1, rdy: 1'b1,
				cnt: '0, st: PLFS_IDLE};
		end else begin
			s_q <= s_d;
		end
	end

	assign link.data_dev = s_q.dout;
	assign link.data_dev_oe_n = s_q.oe_n;
	assign link.ready_busy_flag = s_q.rdy;
	assign prot_o = s_q.prot;
endmodule : plfs_device
`default_nettype wire

// File: core/plfs_programmer.sv
// Programmer end: host register port driving the parallel sequence
`timescale 1ns/1ps
`default_nettype none
module plfs_programmer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Host register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Link
	plfs_if.prg link
);
	import plfs_pkg::*;

	typedef struct packed {
		plfs_prg_state_t st;
		logic [1:0] op;
		logic [7:0] arg;
		logic bs;
		logic [7:0] result;
		logic done;
		logic [3:0] tmr;
		logic [1:0] rdy_s;
		logic [7:0] rdata;
		logic [7:0] dout;
		logic doe_n;
		logic [1:0] xa;
		logic ld;
		logic oe_n;
		logic wr_n;
		logic seen_busy;
	} plfs_prg_t;

	plfs_prg_t s_q;
	plfs_prg_t s_d;
	logic [7:0] din_s1_q;
	logic [7:0] din_s2_q;

	// Step holds each strobe phase long enough for the device synchronisers
	always_comb begin
		s_d = s_q;
		s_d.rdy_s = {s_q.rdy_s[0], link.ready_busy_flag};
		s_d.tmr = s_q.tmr + 1'b1;
		s_d.rdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				REG_STAT: s_d.rdata = {6'h00, s_q.done, s_q.st == PLFS_P_IDLE};
				REG_RESULT: s_d.rdata = s_q.result;
				REG_DATA: s_d.rdata = s_q.arg;
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (wr_i && addr_i == REG_DATA) begin
			s_d.arg = wdata_i;
		end
		unique case (s_q.st)
			PLFS_P_IDLE: begin
				if (wr_i && addr_i == REG_CTRL && s_q.rdy_s[1]) begin
					s_d.op = wdata_i[1:0];
					s_d.bs = wdata_i[2];
					s_d.done = 1'b0;
					s_d.tmr = '0;
					s_d.st = PLFS_P_CMD;
				end
			end
			PLFS_P_CMD: begin
				s_d.doe_n = 1'b0;
				s_d.xa = 2'h2;
				unique case (s_q.op)
					OP_PROT: s_d.dout = CMD_PROT_PROG;
					OP_CFG: s_d.dout = CMD_CFG_READ;
					OP_SIG: s_d.dout = CMD_SIG_READ;
					default: s_d.dout = CMD_CHIP_ERASE;
				endcase
				s_d.ld = (s_q.tmr[3:2] == 2'h1);
				if (&s_q.tmr) begin
					s_d.tmr = '0;
					s_d.st = (s_q.op == OP_SIG) ? PLFS_P_ADDR : (s_q.op == OP_PROT) ? PLFS_P_DATA :
						(s_q.op == OP_CFG) ? PLFS_P_RD : PLFS_P_WR;
				end
			end
			PLFS_P_ADDR: begin
				s_d.xa = 2'h0;
				s_d.dout = s_q.arg;
				s_d.ld = (s_q.tmr[3:2] == 2'h1);
				if (&s_q.tmr) begin
					s_d.tmr = '0;
					s_d.st = PLFS_P_RD;
				end
			end
			PLFS_P_DATA: begin
				s_d.xa = 2'h1;
				s_d.dout = (s_q.arg & PROT_MASK) | RESERVED_ONES;
				s_d.ld = (s_q.tmr[3:2] == 2'h1);
				if (&s_q.tmr) begin
					s_d.tmr = '0;
					s_d.st = PLFS_P_WR;
				end
			end
			PLFS_P_WR: begin
				s_d.doe_n = 1'b1;
				s_d.wr_n = !(s_q.tmr[3:2] == 2'h1);
				if (&s_q.tmr) begin
					s_d.tmr = '0;
					s_d.seen_busy = 1'b0;
					s_d.st = PLFS_P_WAIT;
				end
			end
			// Busy shows up long after the strobe, so ready alone would end the wait at once;
			// a device that never goes busy leaves the programmer waiting here
			PLFS_P_WAIT: begin
				if (!s_q.rdy_s[1]) begin
					s_d.seen_busy = 1'b1;
				end else if (s_q.seen_busy) begin
					s_d.st = PLFS_P_DONE;
				end
			end
			PLFS_P_RD: begin
				s_d.doe_n = 1'b1;
				s_d.oe_n = 1'b0;
				if (&s_q.tmr) begin
					s_d.result = din_s2_q;
					s_d.oe_n = 1'b1;
					s_d.st = PLFS_P_DONE;
				end
			end
			PLFS_P_DONE: begin
				s_d.done = 1'b1;
				s_d.st = PLFS_P_IDLE;
			end
			default: s_d.st = PLFS_P_IDLE;
		endcase
		// Byte select is taken at the start command and held until the next start
		s_d.bs = (s_q.st == PLFS_P_IDLE) ? s_d.bs : s_q.bs;
	end

	// State registers and data synchroniser
	always_ff @(posedge mclk_i) begin
		din_s1_q <= link.data_bus;
		din_s2_q <= din_s1_q;
		if (srst_i) begin
			s_q <= '{st: PLFS_P_IDLE, op: 2'h0, arg: 8'hff, bs: 1'b0, result: 8'h00, done: 1'b0,
				tmr: 4'h0, rdy_s: 2'h0, rdata: 8'h00, dout: 8'hff, doe_n: 1'b1, xa: 2'h0,
				ld: 1'b0, oe_n: 1'b1, wr_n: 1'b1, seen_busy: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign link.data_prg = s_q.dout;
	assign link.data_prg_oe_n = s_q.doe_n;
	assign link.xa = s_q.xa;
	assign link.load_strobe = s_q.ld;
	assign link.read_en_n = s_q.oe_n;
	assign link.byte_select_line = s_q.bs;
	assign link.write_strobe_n = s_q.wr_n;
endmodule : plfs_programmer
`default_nettype wire

// File: verification/plfs_assertions.sv
// Checker of the link between the programmer end and the device end
`timescale 1ns/1ps
`default_nettype none
module plfs_checker #(
	parameter int PROG_CYC = 300
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Link signals
	input wire logic [7:0] data_bus,
	input wire logic [7:0] data_dev,
	input wire logic data_dev_oe_n,
	input wire logic [1:0] xa,
	input wire logic load_strobe,
	input wire logic read_en_n,
	input wire logic byte_select_line,
	input wire logic write_strobe_n,
	input wire logic ready_busy_flag,
	// Device side values
	input wire logic [4:0] fuse_i,
	input wire logic [1:0] prot_o
);
	import plfs_pkg::*;
	logic [7:0] cmd_q;
	logic [7:0] adr_q;
	logic [19:0] cnt_q;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// ----------------------------------------
	// Helpers: last command, address, cycles since write
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cmd_q <= 8'h00;
			adr_q <= 8'h00;
			cnt_q <= 20'h0;
		end else begin
			if (load_strobe && xa == 2'h2) cmd_q <= data_bus;
			if (load_strobe && xa == 2'h0) adr_q <= data_bus;
			// Saturate so a long idle never wraps into a false window
			if ($fell(write_strobe_n)) cnt_q <= 20'h0;
			else if (cnt_q != 20'hfffff) cnt_q <= cnt_q + 20'h1;
		end
	end
	function automatic logic [7:0] sig_exp(input logic [7:0] a, input logic b);
		sig_exp = b ? CAL_BYTE : (a == 8'h0 ? SIG_BYTE_0 : (a == 8'h1 ? SIG_BYTE_1 : SIG_BYTE_2));
	endfunction : sig_exp
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	busy_low_a: assert property ($fell(write_strobe_n) |-> ##[1:500] !ready_busy_flag)
		else $error("busy flag late after write");
	ready_time_a: assert property ($rose(ready_busy_flag) |-> cnt_q >= PROG_CYC && cnt_q <= PROG_CYC + 500)
		else $error("ready returned outside its window");
	lines_release_a: assert property ($rose(read_en_n) |-> ##[1:6] data_dev_oe_n)
		else $error("data lines not released");
	lines_idle_a: assert property (read_en_n [*6] |-> data_dev_oe_n)
		else $error("device drives without read");
	prot_keep_a: assert property (|(prot_o & ~$past(prot_o)) |-> cmd_q == CMD_CHIP_ERASE)
		else $error("protection cleared without erase");
	fuse_read_a: assert property (!read_en_n && !data_dev_oe_n && cmd_q == CMD_CFG_READ && !byte_select_line
		|-> data_dev[4:0] == fuse_i)
		else $error("fuse read value wrong");
	prot_read_a: assert property (!read_en_n && !data_dev_oe_n && cmd_q == CMD_CFG_READ && byte_select_line
		|-> data_dev[2:1] == prot_o)
		else $error("protection read value wrong");
	sig_read_a: assert property (!read_en_n && !data_dev_oe_n && cmd_q == CMD_SIG_READ && adr_q <= SIG_LAST_ADDR
		&& (!byte_select_line || adr_q == 8'h0) |-> data_dev == sig_exp(adr_q, byte_select_line))
		else $error("signature read value wrong");
	// Main scenarios
	cover property ($rose(ready_busy_flag));
	cover property (!data_dev_oe_n && cmd_q == CMD_SIG_READ && byte_select_line);
	cover property ($fell(write_strobe_n) && cmd_q == CMD_CHIP_ERASE);
endmodule : plfs_checker
`default_nettype wire

// File: verification/parallel_lock_fuse_signature_access_tb.sv
// Testbench joining both ends through the link
`timescale 1ns/1ps
`default_nettype none
module parallel_lock_fuse_signature_access_tb;
	import plfs_pkg::*;
	typedef struct packed {
		logic [1:0] op;
		logic bs;
		logic [7:0] dat;
		logic [4:0] fuse;
		logic [7:0] exp;
		logic [7:0] msk;
	} plfs_row_t;
	logic mclk_i;
	logic srst_i;
	logic [3:0] addr_i;
	logic [7:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [7:0] rdata_o;
	logic [4:0] fuse_i;
	logic [1:0] prot_o;
	logic [7:0] res;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;
	plfs_row_t rows [7] = '{
		'{OP_CFG, 1'b0, 8'h00, 5'h15, 8'h15, 8'h1f},
		'{OP_CFG, 1'b0, 8'h00, 5'h0a, 8'h0a, 8'h1f},
		'{OP_SIG, 1'b0, 8'h00, 5'h0a, SIG_BYTE_0, 8'hff},
		'{OP_SIG, 1'b0, 8'h01, 5'h0a, SIG_BYTE_1, 8'hff},
		'{OP_SIG, 1'b0, 8'h02, 5'h0a, SIG_BYTE_2, 8'hff},
		'{OP_SIG, 1'b1, 8'h00, 5'h0a, CAL_BYTE, 8'hff},
		'{OP_CFG, 1'b1, 8'h00, 5'h0a, 8'h06, 8'h06}
	};
	// Protection data bytes and the bits they should leave
	logic [7:0] pd [4] = '{8'hfb, 8'hff, 8'hf9, 8'hff};
	logic [7:0] pe [4] = '{8'h01, 8'h01, 8'h00, 8'h03};
	plfs_if u_plfs_if ();
	plfs_device #(.PROG_CYC(300)) u_plfs_device (.mclk_i(mclk_i), .srst_i(srst_i), .link(u_plfs_if),
		.fuse_i(fuse_i), .prot_o(prot_o));
	plfs_programmer u_plfs_programmer (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(u_plfs_if));
	plfs_checker #(.PROG_CYC(300)) u_plfs_checker (.mclk_i(mclk_i), .srst_i(srst_i),
		.data_bus(u_plfs_if.data_bus), .data_dev(u_plfs_if.data_dev), .data_dev_oe_n(u_plfs_if.data_dev_oe_n),
		.xa(u_plfs_if.xa), .load_strobe(u_plfs_if.load_strobe), .read_en_n(u_plfs_if.read_en_n),
		.byte_select_line(u_plfs_if.byte_select_line), .write_strobe_n(u_plfs_if.write_strobe_n),
		.ready_busy_flag(u_plfs_if.ready_busy_flag), .fuse_i(fuse_i), .prot_o(prot_o));
	// ----------------------------------------
	// Clock, watchdog and host port tasks
	// ----------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// Thirteen operations of under a thousand cycles each fit well below this
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	// Old done flag clears on the clock edge that takes the start write
	task automatic run_op(input logic [1:0] op, input logic bs, input logic [7:0] d, output logic [7:0] r);
		logic [7:0] st;
		int n;
		wr(REG_DATA, d);
		wr(REG_CTRL, {5'h00, bs, op});
		repeat (4) @(posedge mclk_i);
		st = 8'h00;
		n = 0;
		while (st[1] !== 1'b1 && n < 5000) begin
			rd(REG_STAT, st);
			n++;
		end
		check(st & 8'h02, 8'h02);
		rd(REG_RESULT, r);
	endtask : run_op
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		srst_i = 1'b1;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		fuse_i = 5'h15;
		repeat (12) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		#1 check({6'h00, prot_o}, 8'h03);
		check({7'h00, u_plfs_if.data_dev_oe_n}, 8'h01);
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			fuse_i <= rows[i].fuse;
			run_op(rows[i].op, rows[i].bs, rows[i].dat, res);
			check(res & rows[i].msk, rows[i].exp & rows[i].msk);
			$display("test row %0d done", i);
		end
		// Program, try to undo, program the other, then erase
		for (int k = 0; k < 4; k++) begin
			run_op(k == 3 ? OP_ERASE : OP_PROT, 1'b0, pd[k], res);
			check({6'h00, prot_o}, pe[k]);
			if (k == 0) begin
				run_op(OP_CFG, 1'b1, 8'h00, res);
				check(res & 8'h06, 8'h02);
			end
			$display("test protect %0d done", k);
		end
		// Mid-run reset: the link must idle and a read must work again
		@(posedge mclk_i);
		srst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		srst_i <= 1'b0;
		@(posedge mclk_i);
		#1 check({7'h00, u_plfs_if.ready_busy_flag}, 8'h01);
		check({7'h00, u_plfs_if.data_dev_oe_n}, 8'h01);
		run_op(OP_SIG, 1'b0, 8'h01, res);
		check(res, SIG_BYTE_1);
		$display("test mid reset done");
		report_and_stop();
	end
endmodule : parallel_lock_fuse_signature_access_tb
`default_nettype wire
